// ### design/mmd_pkg.sv
// Constants for the memory map decode block: address widths, data-space
// region limits, vector table layout and flash configuration word locations.
// Assumes word addressing throughout; no byte addresses appear anywhere.
package mmd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PADDR_W   = 21;
  localparam int DADDR_W   = 24;
  localparam int WORD_W    = 16;
  localparam int LONG_W    = 32;
  localparam int VEC_W     = 7;
  localparam int TARGET_W  = 19;
  localparam int CFG_WORDS = 9;
  localparam int CFG_IDX_W = 4;
  localparam int REGION_W  = 3;
  localparam int NREGION   = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Vector table
  localparam logic [WORD_W-1:0] VBA_BOOT   = 16'h0200;
  localparam logic [WORD_W-1:0] VBA_ZERO   = 16'h0000;
  localparam int                VBA_SHIFT  = 8;
  localparam logic [VEC_W-1:0]  RESET_SLOTS = 7'h02;
  localparam int                TGT_HI_W   = TARGET_W - WORD_W;

  ////////////////////////////////////////////////////////////////////////////
  // Flash configuration words at the top of program flash
  localparam logic [PADDR_W-1:0] CFG_FIRST_ADDR = 21'h00FFF7;
  localparam logic [CFG_IDX_W-1:0] CFG_LAST_IDX = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Program-space flash blocks
  localparam logic [PADDR_W-1:0] PFLASH_BASE = 21'h008000;
  localparam logic [PADDR_W-1:0] PFLASH_END  = 21'h00FFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Data-space map, word addresses
  localparam logic [DADDR_W-1:0] RAM_BASE    = 24'h000000;
  localparam logic [DADDR_W-1:0] RAM_END     = 24'h000FFF;
  localparam logic [DADDR_W-1:0] DFLASH_BASE = 24'h001000;
  localparam logic [DADDR_W-1:0] DFLASH_END  = 24'h001FFF;
  localparam logic [DADDR_W-1:0] EXT_LO_BASE = 24'h002000;
  localparam logic [DADDR_W-1:0] PERIPH_BASE = 24'h00F000;
  localparam logic [DADDR_W-1:0] PERIPH_END  = 24'h00FFFF;
  localparam logic [DADDR_W-1:0] EXT_HI_BASE = 24'h010000;
  localparam logic [DADDR_W-1:0] DEBUG_BASE  = 24'hFFFF00;
  localparam int                 RAM_DEPTH   = 2048;
  localparam int                 RAM_IDX_W   = 11;

  // Region codes; NONE is no target
  localparam logic [REGION_W-1:0] RGN_RAM    = 3'h0;
  localparam logic [REGION_W-1:0] RGN_DFLASH = 3'h1;
  localparam logic [REGION_W-1:0] RGN_EXT    = 3'h2;
  localparam logic [REGION_W-1:0] RGN_PERIPH = 3'h3;
  localparam logic [REGION_W-1:0] RGN_DEBUG  = 3'h4;
  localparam logic [REGION_W-1:0] RGN_NONE   = 3'h7;

  // Program flash block codes
  typedef enum logic [1:0] {
    MMD_BLK_NONE,
    MMD_BLK_PFLASH,
    MMD_BLK_BOOT
  } mmd_pblk_t;

endpackage : mmd_pkg

// ### design/mmd_ram.sv
// On-chip data RAM held as long words, with per-half write and a registered
// read that already returns the addressed word or the whole long word.
// Assumes the caller only enables it for addresses decoded to the RAM.
`timescale 1ns/1ps

module mmd_ram #(
  parameter int DEPTH = 2048,
  parameter int IDX_W = 11
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Access
  input  wire logic              en_i,
  input  wire logic              we_i,
  input  wire logic              long_i,
  input  wire logic              lane_i,
  input  wire logic [IDX_W-1:0]  idx_i,
  input  wire logic [31:0]       wdata_i,
  output logic      [31:0]       rdata_o
);

  logic [31:0] mem [DEPTH];
  logic [31:0] next_rdata;
  logic [31:0] next_word;

  if (DEPTH > (1 << IDX_W) || DEPTH < 2) begin : g_chk
    $error("mmd_ram: depth does not fit the index");
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_rdata = rdata_o;
    next_word  = mem[idx_i];
    if (en_i && !we_i) begin
      if (long_i) begin
        next_rdata = mem[idx_i];
      end else if (lane_i) begin
        next_rdata = {16'h0000, mem[idx_i][31:16]};
      end else begin
        next_rdata = {16'h0000, mem[idx_i][15:0]};
      end
    end
    if (long_i) begin
      next_word = wdata_i;
    end else if (lane_i) begin
      next_word = {wdata_i[15:0], mem[idx_i][15:0]};
    end else begin
      next_word = {mem[idx_i][31:16], wdata_i[15:0]};
    end
  end

  // Storage has no reset
  always_ff @(posedge clk_i) begin
    if (ce_i && en_i && we_i) begin
      mem[idx_i] <= next_word;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (ce_i) begin
      rdata_o <= next_rdata;
    end
  end

endmodule : mmd_ram

// ### design/mmd_top.sv
// Memory map decode: flash configuration load at start-up, vector table
// fetch with 19-bit targets, and data-space region decode with the data RAM.
// Assumes program reads are acknowledged by PROG_ACK_I with data alongside.
//
// Operation
// - A vector entry is two consecutive words at the vector base plus twice the vector number.
// - A jump target read from the table is cut to a 19-bit address.
// - With the boot vector base the first two table slots are reset addresses, not vectors.
// - Every data-space address is decoded as a 24-bit word address.
// - The data RAM is 2K long words so that a long access completes in one cycle.
// - At initialisation the top nine program flash words are copied into the config registers.
// - Config words live in flash, so they are reloaded after every reset.
// - Flash is split into program flash, boot flash and data flash blocks.
// - Program and boot flash share the program read port; data flash is reached through the data-space decode.
`timescale 1ns/1ps

module mmd_top
  import mmd_pkg::*;
#(
  parameter bit                    HAS_DATA_FLASH   = 1'b1,
  parameter bit                    EXT_MEM_PRESENT  = 1'b0,
  parameter logic [PADDR_W-1:0]    BOOT_FLASH_BASE  = 21'h020000,
  parameter int                    BOOT_FLASH_WORDS = 4096
) (
  // Clock and reset
  input  wire logic                          CLOCK_I,
  input  wire logic                          RST_I,
  input  wire logic                          CE_I,
  // Mode straps
  input  wire logic [mmd_pkg::WORD_W-1:0]    VECTOR_BASE_I,
  input  wire logic                          BOOT_MODE1_I,
  input  wire logic                          EXT_MEM_BOOT_MODE_I,
  input  wire logic                          EXTERNAL_DATA_ENABLE_I,
  // Program read port
  output logic                               PROG_RD_O,
  output logic      [mmd_pkg::PADDR_W-1:0]   PROG_ADDR_O,
  output logic      [1:0]                    PROG_BLOCK_O,
  input  wire logic                          PROG_ACK_I,
  input  wire logic [mmd_pkg::WORD_W-1:0]    PROG_RDATA_I,
  // Flash configuration
  output logic      [mmd_pkg::CFG_WORDS*mmd_pkg::WORD_W-1:0] CFG_WORDS_O,
  output logic                               INIT_DONE_O,
  // Vector fetch
  input  wire logic                          VEC_REQ_I,
  input  wire logic [mmd_pkg::VEC_W-1:0]     VEC_NUM_I,
  output logic                               VEC_READY_O,
  output logic                               VEC_DONE_O,
  output logic                               VEC_RESERVED_O,
  output logic      [mmd_pkg::TARGET_W-1:0]  VEC_TARGET_O,
  // Data access
  input  wire logic                          DATA_REQ_I,
  input  wire logic                          DATA_WE_I,
  input  wire logic                          DATA_LONG_I,
  input  wire logic [mmd_pkg::DADDR_W-1:0]   DATA_ADDR_I,
  input  wire logic [mmd_pkg::LONG_W-1:0]    DATA_WDATA_I,
  output logic                               DATA_VALID_O,
  output logic      [mmd_pkg::NREGION-1:0]   DATA_SEL_O,
  output logic                               DATA_MISS_O,
  output logic      [mmd_pkg::DADDR_W-1:0]   DATA_OFFSET_O,
  output logic      [mmd_pkg::LONG_W-1:0]    DATA_RDATA_O
);

  import mmd_pkg::*;

  if (BOOT_FLASH_WORDS < 1 || BOOT_FLASH_WORDS > (1 << (PADDR_W - 1))) begin : g_chk
    $error("mmd_top: boot flash size out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding functions

  function automatic mmd_pblk_t prog_block(input logic [PADDR_W-1:0] a);
    if (a >= PFLASH_BASE && a <= PFLASH_END) begin
      return MMD_BLK_PFLASH;
    end else if (a >= BOOT_FLASH_BASE &&
                 a < BOOT_FLASH_BASE + PADDR_W'(BOOT_FLASH_WORDS)) begin
      return MMD_BLK_BOOT;
    end
    return MMD_BLK_NONE;
  endfunction : prog_block

  function automatic logic [REGION_W-1:0] data_region(input logic [DADDR_W-1:0] a,
                                                      input logic ex_en);
    if (a >= DEBUG_BASE) begin
      return RGN_DEBUG;
    end else if (a >= PERIPH_BASE && a <= PERIPH_END) begin
      return RGN_PERIPH;
    end else if (a <= DFLASH_END && !ex_en) begin
      if (a <= RAM_END) begin
        return RGN_RAM;
      end
      return HAS_DATA_FLASH ? RGN_DFLASH : RGN_NONE;
    end
    return EXT_MEM_PRESENT ? RGN_EXT : RGN_NONE;
  endfunction : data_region

  function automatic logic [DADDR_W-1:0] region_base(input logic [REGION_W-1:0] r,
                                                     input logic [DADDR_W-1:0] a);
    case (r)
      RGN_RAM:    return RAM_BASE;
      RGN_DFLASH: return DFLASH_BASE;
      RGN_PERIPH: return PERIPH_BASE;
      RGN_DEBUG:  return DEBUG_BASE;
      RGN_EXT:    return (a >= EXT_HI_BASE) ? EXT_HI_BASE : EXT_LO_BASE;
      default:    return a;
    endcase
  endfunction : region_base

  ////////////////////////////////////////////////////////////////////////////
  // Program port sequencer

  typedef enum logic [1:0] {
    ST_CFG,
    ST_IDLE,
    ST_VEC_LO,
    ST_VEC_HI
  } mmd_state_t;

  mmd_state_t            state;
  mmd_state_t            next_state;
  logic                  next_prog_rd;
  logic [PADDR_W-1:0]    next_prog_addr;
  logic [1:0]            next_prog_block;
  logic [CFG_IDX_W-1:0]  cfg_idx;
  logic [CFG_IDX_W-1:0]  next_cfg_idx;
  logic [WORD_W-1:0]     cfg [CFG_WORDS];
  logic [WORD_W-1:0]     next_cfg [CFG_WORDS];
  logic                  next_init_done;
  logic                  next_vec_ready;
  logic                  next_vec_done;
  logic                  next_vec_reserved;
  logic [TARGET_W-1:0]   next_vec_target;
  logic [WORD_W-1:0]     vec_lo;
  logic [WORD_W-1:0]     next_vec_lo;
  logic                  boot_base;
  logic [PADDR_W-1:0]    entry_addr;

  // Base selects the boot location
  assign boot_base = (VECTOR_BASE_I == VBA_BOOT) ||
                     (VECTOR_BASE_I == VBA_ZERO && BOOT_MODE1_I && !EXT_MEM_BOOT_MODE_I);
  assign entry_addr = (PADDR_W'(VECTOR_BASE_I) << VBA_SHIFT) +
                      PADDR_W'({VEC_NUM_I, 1'b0});

  for (genvar i = 0; i < CFG_WORDS; i++) begin : g_cfg_out
    assign CFG_WORDS_O[i*WORD_W +: WORD_W] = cfg[i];
  end

  always_comb begin
    next_state        = state;
    next_prog_rd      = PROG_RD_O;
    next_prog_addr    = PROG_ADDR_O;
    next_cfg_idx      = cfg_idx;
    next_cfg          = cfg;
    next_init_done    = INIT_DONE_O;
    next_vec_done     = 1'b0;
    next_vec_reserved = VEC_RESERVED_O;
    next_vec_target   = VEC_TARGET_O;
    next_vec_lo       = vec_lo;
    case (state)
      ST_CFG: begin
        if (!PROG_RD_O) begin
          next_prog_rd   = 1'b1;
          next_prog_addr = CFG_FIRST_ADDR + PADDR_W'(cfg_idx);
        end else if (PROG_ACK_I) begin
          next_prog_rd     = 1'b0;
          next_cfg[cfg_idx] = PROG_RDATA_I;
          if (cfg_idx == CFG_LAST_IDX) begin
            next_init_done = 1'b1;
            next_state     = ST_IDLE;
          end else begin
            next_cfg_idx = cfg_idx + 4'h1;
          end
        end
      end
      ST_IDLE: begin
        if (VEC_REQ_I) begin
          if (boot_base && VEC_NUM_I < RESET_SLOTS) begin
            next_vec_done     = 1'b1;
            next_vec_reserved = 1'b1;
            next_vec_target   = '0;
          end else begin
            next_vec_reserved = 1'b0;
            next_prog_rd      = 1'b1;
            next_prog_addr    = entry_addr;
            next_state        = ST_VEC_LO;
          end
        end
      end
      ST_VEC_LO: begin
        if (PROG_ACK_I) begin
          next_vec_lo    = PROG_RDATA_I;
          next_prog_addr = PROG_ADDR_O + 21'h000001;
          next_state     = ST_VEC_HI;
        end
      end
      ST_VEC_HI: begin
        if (PROG_ACK_I) begin
          next_prog_rd    = 1'b0;
          next_vec_target = {PROG_RDATA_I[TGT_HI_W-1:0], vec_lo};
          next_vec_done   = 1'b1;
          next_state      = ST_IDLE;
        end
      end
      default: begin
        next_state   = ST_CFG;
        next_prog_rd = 1'b0;
      end
    endcase
    next_prog_block = prog_block(next_prog_addr);
    next_vec_ready  = (next_state == ST_IDLE);
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state          <= ST_CFG;
      PROG_RD_O      <= 1'b0;
      PROG_ADDR_O    <= '0;
      PROG_BLOCK_O   <= 2'h0;
      cfg_idx        <= '0;
      cfg            <= '{default: '0};
      INIT_DONE_O    <= 1'b0;
      VEC_READY_O    <= 1'b0;
      VEC_DONE_O     <= 1'b0;
      VEC_RESERVED_O <= 1'b0;
      VEC_TARGET_O   <= '0;
      vec_lo         <= '0;
    end else if (CE_I) begin
      state          <= next_state;
      PROG_RD_O      <= next_prog_rd;
      PROG_ADDR_O    <= next_prog_addr;
      PROG_BLOCK_O   <= next_prog_block;
      cfg_idx        <= next_cfg_idx;
      cfg            <= next_cfg;
      INIT_DONE_O    <= next_init_done;
      VEC_READY_O    <= next_vec_ready;
      VEC_DONE_O     <= next_vec_done;
      VEC_RESERVED_O <= next_vec_reserved;
      VEC_TARGET_O   <= next_vec_target;
      vec_lo         <= next_vec_lo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-space decode

  logic [REGION_W-1:0]  rgn;
  logic [NREGION-1:0]   next_sel;
  logic                 next_miss;
  logic                 next_valid;
  logic [DADDR_W-1:0]   next_offset;
  logic                 ram_en;

  // Whole address is a word address; bit 0 picks the RAM half
  assign rgn    = data_region(DATA_ADDR_I, EXTERNAL_DATA_ENABLE_I);
  assign ram_en = DATA_REQ_I && (rgn == RGN_RAM);

  for (genvar r = 0; r < NREGION; r++) begin : g_sel
    assign next_sel[r] = DATA_REQ_I && (rgn == REGION_W'(r));
  end

  always_comb begin
    next_valid  = DATA_REQ_I;
    next_miss   = DATA_REQ_I && (rgn == RGN_NONE);
    next_offset = DATA_REQ_I ? (DATA_ADDR_I - region_base(rgn, DATA_ADDR_I)) : '0;
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      DATA_VALID_O  <= 1'b0;
      DATA_SEL_O    <= '0;
      DATA_MISS_O   <= 1'b0;
      DATA_OFFSET_O <= '0;
    end else if (CE_I) begin
      DATA_VALID_O  <= next_valid;
      DATA_SEL_O    <= next_sel;
      DATA_MISS_O   <= next_miss;
      DATA_OFFSET_O <= next_offset;
    end
  end

  mmd_ram #(
    .DEPTH (RAM_DEPTH),
    .IDX_W (RAM_IDX_W)
  ) u_ram (
    .clk_i   (CLOCK_I),
    .rst_i   (RST_I),
    .ce_i    (CE_I),
    .en_i    (ram_en),
    .we_i    (DATA_WE_I),
    .long_i  (DATA_LONG_I),
    .lane_i  (DATA_ADDR_I[0]),
    .idx_i   (DATA_ADDR_I[RAM_IDX_W:1]),
    .wdata_i (DATA_WDATA_I),
    .rdata_o (DATA_RDATA_O)
  );

endmodule : mmd_top

// ### tb/memory_map_decode_tb.sv
// Self-checking bench for the memory map decode top level
// Assumes the flash model answers program reads; one 40 MHz clock
`timescale 1ns/1ps

module memory_map_decode_tb;
  import mmd_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, mode1 = 1'b0, xboot = 1'b0, ex = 1'b0;
  logic [15:0] vbase = 16'h0;
  logic [6:0] vnum = 7'h0;
  logic vreq = 1'b0, dreq = 1'b0, dwe = 1'b0, dlong = 1'b0;
  logic [23:0] daddr = 24'h0;
  logic [31:0] dwdata = 32'h0;
  logic [3:0] dly = 4'h2;
  logic prd, pack, idone, vrdy, vdone, vrsv, dvalid, dmiss;
  logic [20:0] padr;
  logic [1:0] pblk;
  logic [15:0] prdata;
  logic [143:0] cfg;
  logic [18:0] vtgt;
  logic [4:0] dsel;
  logic [23:0] doff;
  logic [31:0] drdata, sh [0:2047], seed = 32'h9AFD;
  bit ok [0:2047];
  int fail_count = 0;
  int cmp_count = 0;

  always #12.5 clk = ~clk;

  mmd_top dut_u (
    .CLOCK_I(clk), .RST_I(rst), .CE_I(ce), .VECTOR_BASE_I(vbase), .BOOT_MODE1_I(mode1),
    .EXT_MEM_BOOT_MODE_I(xboot), .EXTERNAL_DATA_ENABLE_I(ex), .PROG_RD_O(prd),
    .PROG_ADDR_O(padr), .PROG_BLOCK_O(pblk), .PROG_ACK_I(pack), .PROG_RDATA_I(prdata),
    .CFG_WORDS_O(cfg), .INIT_DONE_O(idone), .VEC_REQ_I(vreq), .VEC_NUM_I(vnum),
    .VEC_READY_O(vrdy), .VEC_DONE_O(vdone), .VEC_RESERVED_O(vrsv), .VEC_TARGET_O(vtgt),
    .DATA_REQ_I(dreq), .DATA_WE_I(dwe), .DATA_LONG_I(dlong), .DATA_ADDR_I(daddr),
    .DATA_WDATA_I(dwdata), .DATA_VALID_O(dvalid), .DATA_SEL_O(dsel), .DATA_MISS_O(dmiss),
    .DATA_OFFSET_O(doff), .DATA_RDATA_O(drdata)
  );

  mmd_flash_model flash_u (
    .clk_i(clk), .rst_i(rst), .rd_i(prd), .addr_i(padr), .dly_i(dly), .ack_o(pack),
    .rdata_o(prdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [15:0] fw(input logic [20:0] ad);
    return ad[15:0] ^ {11'h5A3, ad[20:16]};
  endfunction : fw

  // {miss, sel, offset} expected for a word address
  function automatic logic [29:0] region(input logic [23:0] a);
    if (a <= RAM_END && !ex) return {6'h01, a};
    if (a >= DFLASH_BASE && a <= DFLASH_END && !ex) return {6'h02, a - DFLASH_BASE};
    if (a >= PERIPH_BASE && a <= PERIPH_END) return {6'h08, a - PERIPH_BASE};
    if (a >= DEBUG_BASE) return {6'h10, a - DEBUG_BASE};
    return {6'h20, 24'h0};
  endfunction : region

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic tick();
    @(posedge clk);
    #2;
  endtask : tick

  task automatic check_load();
    int i;
    for (i = 0; i < 400 && idone !== 1'b1; i++) tick();
    if (idone !== 1'b1) begin
      fail_count++;
      final_report();
    end
    for (i = 0; i < CFG_WORDS; i++) check(32'(cfg[16*i +: 16]), 32'(fw(CFG_FIRST_ADDR + 21'(i))));
    check(32'(vrdy), 32'h1);
  endtask : check_load

  task automatic vec(input logic [15:0] b, input logic m1, input logic xb, input logic [6:0] n);
    logic [20:0] ad;
    logic [15:0] w1;
    logic r;
    int i;
    ad = 21'({b, 8'h00}) + 21'({n, 1'b0});
    w1 = fw(ad + 21'h1);
    r = (n < 7'h02) && (b == VBA_BOOT || (b == VBA_ZERO && m1 && !xb));
    vbase = b;
    mode1 = m1;
    xboot = xb;
    vnum = n;
    vreq = 1'b1;
    tick();
    vreq = 1'b0;
    for (i = 0; i < 60 && vdone !== 1'b1; i++) tick();
    if (vdone !== 1'b1) begin
      fail_count++;
      final_report();
    end
    check(32'(vrsv), 32'(r));
    check(32'(vtgt), r ? 32'h0 : 32'({w1[2:0], fw(ad)}));
    tick();
  endtask : vec

  task automatic dat(input logic w, input logic l, input logic [23:0] ad, input logic [31:0] wd);
    logic [29:0] e;
    logic [10:0] ix;
    logic [31:0] x;
    e = region(ad);
    ix = ad[11:1];
    dreq = 1'b1;
    dwe = w;
    dlong = l;
    daddr = ad;
    dwdata = wd;
    tick();
    check(32'(dvalid), 32'h1);
    check(32'({dmiss, dsel}), 32'(e[29:24]));
    check(32'(doff), 32'(e[23:0]));
    x = l ? sh[ix] : (ad[0] ? {16'h0, sh[ix][31:16]} : {16'h0, sh[ix][15:0]});
    if (e[24] && !w && ok[ix]) check(drdata, x);
    if (e[24] && w && l) begin
      sh[ix] = wd;
      ok[ix] = 1'b1;
    end else if (e[24] && w) begin
      if (ad[0]) sh[ix][31:16] = wd[15:0];
      else sh[ix][15:0] = wd[15:0];
    end
  endtask : dat

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    static logic [23:0] rb [0:5] = '{24'h0, 24'h001000, 24'h002000, 24'h00F000,
      24'hFFFF00, 24'h010000};
    static logic [23:0] rm [0:5] = '{24'h3F, 24'hFFF, 24'hCFFF, 24'hFFF, 24'hFF, 24'hFEFEFF};
    static logic [23:0] ca [0:10] = '{24'h000FFF, 24'h001000, 24'h001FFF, 24'h002000, 24'h00EFFF,
      24'h00F000, 24'h00FFFF, 24'h010000, 24'hFFFEFF, 24'hFFFF00, 24'hFFFFFF};
    logic [31:0] r;
    int i;
    int k;
    repeat (8) @(posedge clk);
    #2 rst = 1'b0;
    repeat (4) tick();
    // Reset in mid-load, config must reload
    rst = 1'b1;
    tick();
    rst = 1'b0;
    dly = 4'h0;
    check_load();
    vec(VBA_BOOT, 1'b0, 1'b0, 7'h00);
    vec(VBA_BOOT, 1'b0, 1'b0, 7'h01);
    vec(VBA_BOOT, 1'b0, 1'b0, 7'h02);
    check(32'(pblk), 32'h2);
    vec(VBA_ZERO, 1'b1, 1'b0, 7'h01);
    vec(VBA_ZERO, 1'b1, 1'b1, 7'h00);
    vec(VBA_ZERO, 1'b0, 1'b0, 7'h00);
    vec(16'h1FFF, 1'b0, 1'b0, 7'h7F);
    for (i = 0; i < 12; i++) begin
      r = rnd();
      dly = {1'b0, r[2:0]};
      vec({3'h0, r[28:16]}, r[4], r[5], r[14:8]);
    end
    dat(1'b1, 1'b1, 24'h000002, 32'hCAFE1234);
    dat(1'b0, 1'b0, 24'h000002, 32'h0);
    dat(1'b0, 1'b0, 24'h000003, 32'h0);
    dat(1'b1, 1'b0, 24'h000003, 32'h0000BEEF);
    dat(1'b0, 1'b1, 24'h000003, 32'h0);
    // Enable low freezes the answer
    ce = 1'b0;
    daddr = 24'h000010;
    tick();
    check(32'({dvalid, doff}), 32'h1000003);
    check(drdata, sh[1]);
    ce = 1'b1;
    for (k = 0; k < 2; k++) begin
      ex = k[0];
      for (i = 0; i < 11; i++) dat(1'b0, 1'b0, ca[i], 32'h0);
    end
    for (i = 0; i < 200; i++) begin
      r = rnd();
      k = int'(r[31:29]) % 6;
      ex = (r[7:5] == 3'h0);
      dat(r[0], r[1], rb[k] | (24'(rnd()) & rm[k]), rnd());
    end
    dreq = 1'b0;
    ex = 1'b0;
    tick();
    final_report();
  end
endmodule : memory_map_decode_tb

// ### tb/mmd_flash_model.sv
// Program flash behind the program read port, with adjustable ack delay
// Assumes the requester holds address and read until the ack edge
`timescale 1ns/1ps

module mmd_flash_model
  import mmd_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               rd_i,
  input  wire logic [PADDR_W-1:0] addr_i,
  input  wire logic [3:0]         dly_i,
  output logic                    ack_o,
  output logic      [WORD_W-1:0]  rdata_o
);
  logic [3:0] cnt;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      ack_o <= 1'b0;
      rdata_o <= 16'h0;
    end else if (rd_i && !ack_o && cnt >= dly_i) begin
      cnt <= 4'h0;
      ack_o <= 1'b1;
      // Contents fixed, survive any reset
      rdata_o <= addr_i[15:0] ^ {11'h5A3, addr_i[20:16]};
    end else begin
      cnt <= (rd_i && !ack_o) ? cnt + 4'h1 : 4'h0;
      ack_o <= 1'b0;
      // Released data line toggles
      rdata_o <= ~rdata_o;
    end
  end
endmodule : mmd_flash_model

// ### tb/mmd_top_monitor.sv
// Concurrent checks on the memory map decode top level ports
// Assumes one clock domain and a bind onto every mmd_top instance
`timescale 1ns/1ps

module mmd_top_monitor
  import mmd_pkg::*;
#(
  parameter bit HAS_DATA_FLASH  = 1'b1,
  parameter bit EXT_MEM_PRESENT = 1'b0
) (
  input wire logic                        CLOCK_I,
  input wire logic                        RST_I,
  input wire logic                        CE_I,
  input wire logic [mmd_pkg::WORD_W-1:0]  VECTOR_BASE_I,
  input wire logic                        BOOT_MODE1_I,
  input wire logic                        EXT_MEM_BOOT_MODE_I,
  input wire logic                        EXTERNAL_DATA_ENABLE_I,
  input wire logic                        PROG_RD_O,
  input wire logic [mmd_pkg::PADDR_W-1:0] PROG_ADDR_O,
  input wire logic [1:0]                  PROG_BLOCK_O,
  input wire logic                        PROG_ACK_I,
  input wire logic                        INIT_DONE_O,
  input wire logic                        VEC_REQ_I,
  input wire logic [mmd_pkg::VEC_W-1:0]   VEC_NUM_I,
  input wire logic                        VEC_READY_O,
  input wire logic                        VEC_DONE_O,
  input wire logic                        VEC_RESERVED_O,
  input wire logic [mmd_pkg::TARGET_W-1:0] VEC_TARGET_O,
  input wire logic                        DATA_REQ_I,
  input wire logic [mmd_pkg::DADDR_W-1:0] DATA_ADDR_I,
  input wire logic                        DATA_VALID_O,
  input wire logic [mmd_pkg::NREGION-1:0] DATA_SEL_O,
  input wire logic                        DATA_MISS_O,
  input wire logic [mmd_pkg::DADDR_W-1:0] DATA_OFFSET_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  ////////////////////////////////////////////////////////////////////////////
  logic [DADDR_W-1:0] a;
  logic               ex;
  logic               rsv;
  logic               ext_hit;
  assign a = DATA_ADDR_I;
  assign ex = EXTERNAL_DATA_ENABLE_I;
  assign rsv = (VEC_NUM_I < 7'h02) && ((VECTOR_BASE_I == VBA_BOOT) ||
               (VECTOR_BASE_I == VBA_ZERO && BOOT_MODE1_I && !EXT_MEM_BOOT_MODE_I));
  assign ext_hit = (a >= EXT_LO_BASE && a < PERIPH_BASE) ||
                   (a >= EXT_HI_BASE && a < DEBUG_BASE) || (a < EXT_LO_BASE && ex);

  sequence vec_take;
    VEC_READY_O && VEC_REQ_I && CE_I;
  endsequence
  sequence dat_take;
    DATA_REQ_I && CE_I;
  endsequence
  sequence fetch_done;
    ##[3:60] VEC_DONE_O;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  data_answer_a: assert property (dat_take |=> DATA_VALID_O)
    else $error("data request not answered");
  one_target_a: assert property (DATA_VALID_O |-> $onehot(DATA_SEL_O) != DATA_MISS_O)
    else $error("data decode not exactly one target");
  ram_word_a: assert property (dat_take and (a <= RAM_END && !ex) |=>
    DATA_SEL_O == 5'h01 && DATA_OFFSET_O == $past(a)) else $error("ram decode wrong");
  dflash_sel_a: assert property (dat_take and (a >= DFLASH_BASE && a <= DFLASH_END && !ex)
    |=> DATA_SEL_O == (HAS_DATA_FLASH ? 5'h02 : 5'h00)) else $error("data flash decode wrong");
  periph_sel_a: assert property (dat_take and (a >= PERIPH_BASE && a <= PERIPH_END) |=>
    DATA_SEL_O == 5'h08 && DATA_OFFSET_O == $past(a) - PERIPH_BASE)
    else $error("peripheral decode wrong");
  debug_sel_a: assert property (dat_take and (a >= DEBUG_BASE) |=>
    DATA_SEL_O == 5'h10 && DATA_OFFSET_O == $past(a) - DEBUG_BASE) else $error("debug decode wrong");
  ext_miss_a: assert property (dat_take and (ext_hit && !EXT_MEM_PRESENT) |=>
    DATA_MISS_O && DATA_SEL_O == 5'h00) else $error("absent region not a miss");
  cfg_fetch_a: assert property (PROG_RD_O && !INIT_DONE_O |->
    PROG_ADDR_O >= CFG_FIRST_ADDR && PROG_ADDR_O <= PFLASH_END && PROG_BLOCK_O == 2'h1)
    else $error("config fetch outside top words");
  prog_hold_a: assert property (PROG_RD_O && !PROG_ACK_I && CE_I |=>
    PROG_RD_O && $stable(PROG_ADDR_O)) else $error("program request dropped");
  vec_entry_a: assert property (vec_take and !rsv |=> PROG_RD_O && PROG_ADDR_O ==
    PADDR_W'({$past(VECTOR_BASE_I), 8'h00}) + PADDR_W'({$past(VEC_NUM_I), 1'b0}))
    else $error("vector entry address wrong");
  vec_reserved_a: assert property (vec_take and rsv |=>
    VEC_DONE_O && VEC_RESERVED_O && VEC_TARGET_O == 19'h0 && !PROG_RD_O)
    else $error("reset slot used as vector");
  vec_bound_a: assert property (vec_take and !rsv |-> fetch_done)
    else $error("vector fetch never finished");
endmodule : mmd_top_monitor

bind mmd_top mmd_top_monitor #(
  .HAS_DATA_FLASH(HAS_DATA_FLASH), .EXT_MEM_PRESENT(EXT_MEM_PRESENT)
) mon_u (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I), .VECTOR_BASE_I(VECTOR_BASE_I),
  .BOOT_MODE1_I(BOOT_MODE1_I), .EXT_MEM_BOOT_MODE_I(EXT_MEM_BOOT_MODE_I),
  .EXTERNAL_DATA_ENABLE_I(EXTERNAL_DATA_ENABLE_I), .PROG_RD_O(PROG_RD_O),
  .PROG_ADDR_O(PROG_ADDR_O), .PROG_BLOCK_O(PROG_BLOCK_O), .PROG_ACK_I(PROG_ACK_I),
  .INIT_DONE_O(INIT_DONE_O), .VEC_REQ_I(VEC_REQ_I), .VEC_NUM_I(VEC_NUM_I),
  .VEC_READY_O(VEC_READY_O), .VEC_DONE_O(VEC_DONE_O), .VEC_RESERVED_O(VEC_RESERVED_O),
  .VEC_TARGET_O(VEC_TARGET_O), .DATA_REQ_I(DATA_REQ_I), .DATA_ADDR_I(DATA_ADDR_I),
  .DATA_VALID_O(DATA_VALID_O), .DATA_SEL_O(DATA_SEL_O), .DATA_MISS_O(DATA_MISS_O),
  .DATA_OFFSET_O(DATA_OFFSET_O)
);
